// ---- ext_irq_defines.vh ----
`ifndef EXT_IRQ_DEFINES_VH
`define EXT_IRQ_DEFINES_VH

// Register offsets on the plain register port.
`define REG_SYSTEM_CONTROL   3'h0
`define REG_SENSE_CONTROL    3'h1
`define REG_ENABLE           3'h2
`define REG_CONTROL_LEVEL    3'h3
`define REG_STATUS           3'h4
`define REG_ACCEPT_VIEW      3'h5

// Field positions and widths.
`define NMI_EDGE_BIT         0
`define ADDR_W               3
`define DATA_W               16
`define LINES                8
`define KEYS                 16
`define SENSE_W              16
`define VECTOR_W             8
`define PIN_COUNT            25

// Reset values.
`define RST_SYSTEM_CONTROL   1'h0
`define RST_SENSE            16'h0000
`define RST_LINE_BYTE        8'h00
`define RST_PINS_IDLE        25'h1FFFFFF
`define RST_LINES_IDLE       8'hFF
`define RST_VECTOR           8'h00
`define RST_DATA             16'h0000

// Sense codes, two bits per line.
`define SENSE_LOW_LEVEL      2'h0
`define SENSE_FALLING        2'h1
`define SENSE_RISING         2'h2
`define SENSE_BOTH           2'h3

// Interrupt control modes.
`define MODE_ZERO            2'h0
`define MODE_ONE             2'h1

// Fixed vector of the non-maskable request and lines allowed to wake.
`define NMI_VECTOR           8'h07
`define WAKE_LINES           8'hC7

`endif

// ---- pin_sync.v ----
`timescale 1ns/1ps

module pin_sync #(
   parameter WIDTH = 25,
   parameter [WIDTH-1:0] IDLE = {WIDTH{1'b1}}
) (
   // Clock and reset
   input  wire             sys_clk_i,
   input  wire             nrst_i,
   // Raw pins and their synchronised copy
   input  wire [WIDTH-1:0] pins_i,
   output reg  [WIDTH-1:0] pins_o
);

   reg [WIDTH-1:0] stage1;

   // Stage one feeds stage two only, so a metastable sample never reaches logic.
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         stage1 <= IDLE;
         pins_o <= IDLE;
      end else begin
         stage1 <= pins_i;
         pins_o <= stage1;
      end
   end

endmodule // pin_sync

// ---- external_interrupt_sources.v ----
`timescale 1ns/1ps
`include "ext_irq_defines.vh"

module external_interrupt_sources #(
   parameter [`VECTOR_W-1:0] IRQ_VECTOR_BASE = 8'h10
) (
   // Clock and reset
   input  wire                 sys_clk_i,
   input  wire                 nrst_i,
   // External request pins, request lines active low
   input  wire                 nmi_pin_i,
   input  wire [`LINES-1:0]    irq_pin_i,
   input  wire [`KEYS-1:0]     key_sense_i,
   // Register port
   input  wire [`ADDR_W-1:0]   addr_i,
   input  wire [`DATA_W-1:0]   wdata_i,
   input  wire                 wr_i,
   input  wire                 rd_i,
   output reg  [`DATA_W-1:0]   rdata_o,
   // CPU core side
   input  wire                 int_mask_i,
   input  wire                 secondary_mask_bit_i,
   input  wire [1:0]           ctrl_mode_i,
   input  wire                 standby_i,
   input  wire                 accept_i,
   output reg                  cpu_irq_o,
   output reg  [`VECTOR_W-1:0] cpu_vector_o,
   output reg                  wake_o
);

   reg                  nonmaskable_edge_select;
   reg [`SENSE_W-1:0]   request_sense_control;
   reg [`LINES-1:0]     request_enable_reg;
   reg [`LINES-1:0]     control_level_reg;
   reg [`LINES-1:0]     request_status_reg;
   reg [`LINES-1:0]     line_prev;
   reg                  nmi_prev;
   reg                  nmi_pending;

   wire [`PIN_COUNT-1:0] pins_sync;
   wire                  nmi_now;
   wire [`LINES-1:0]     irq_now;
   wire [`KEYS-1:0]      key_now;

   reg  [`LINES-1:0]     line_now;
   reg  [`LINES-1:0]     detected;
   reg  [`LINES-1:0]     next_status;
   reg  [`LINES-1:0]     pending;
   reg  [`LINES-1:0]     eligible;
   reg                   allow_level1;
   reg                   allow_level0;
   reg                   nmi_edge;
   reg                   next_nmi_pending;
   reg  [2:0]            pick;
   reg  [`LINES-1:0]     level1_hit;
   reg  [`VECTOR_W:0]    vector_sum;
   reg  [`DATA_W-1:0]    next_rdata;

   // Level sense is decided on the current sample; edges compare two samples.
   function sense_hit;
      input [1:0] code;
      input       now;
      input       prev;
      begin
         case (code)
            `SENSE_LOW_LEVEL: sense_hit = ~now;
            `SENSE_FALLING:   sense_hit = prev & ~now;
            `SENSE_RISING:    sense_hit = ~prev & now;
            `SENSE_BOTH:      sense_hit = prev ^ now;
            default:          sense_hit = 1'b0;
         endcase
      end
   endfunction

   // Lowest numbered set bit wins within one control level.
   function [2:0] lowest_set;
      input [`LINES-1:0] bits;
      integer i;
      begin
         lowest_set = 3'h0;
         for (i = `LINES - 1; i >= 0; i = i - 1) begin
            if (bits[i]) begin
               lowest_set = i[2:0];
            end
         end
      end
   endfunction

   pin_sync #(
      .WIDTH (`PIN_COUNT),
      .IDLE  (`RST_PINS_IDLE)
   ) u_pin_sync (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .pins_i    ({nmi_pin_i, irq_pin_i, key_sense_i}),
      .pins_o    (pins_sync)
   );

   assign nmi_now = pins_sync[`PIN_COUNT-1];
   assign irq_now = pins_sync[`KEYS+`LINES-1:`KEYS];
   assign key_now = pins_sync[`KEYS-1:0];

   integer n;

   // Write decode shared by every register process.
   function reg_hit;
      input [`ADDR_W-1:0] addr;
      input               strobe;
      input [`ADDR_W-1:0] offset;
      begin
         reg_hit = strobe && addr == offset;
      end
   endfunction

   // Shared sources: a key pulled low pulls its line low.
   always @* begin
      line_now    = irq_now;
      line_now[7] = irq_now[7] & (&key_now[15:8]);
      line_now[6] = irq_now[6] & (&key_now[7:0]);
      // Lines 0 and 1 listen to their pin only while enabled; otherwise idle high.
      line_now[0] = request_enable_reg[0] ? irq_now[0] : 1'b1;
      line_now[1] = request_enable_reg[1] ? irq_now[1] : 1'b1;
   end

   // Enabling line 0 or 1 while its pin is low counts as a falling edge.
   always @* begin
      detected = `RST_LINE_BYTE;
      for (n = 0; n < `LINES; n = n + 1) begin
         detected[n] = sense_hit(request_sense_control[2*n+1 -: 2],
                                 line_now[n], line_prev[n]);
      end
   end

   // A new detection beats a clear written in the same cycle.
   always @* begin
      next_status = request_status_reg | detected;
      if (reg_hit(addr_i, wr_i, `REG_STATUS)) begin
         next_status = (request_status_reg & wdata_i[`LINES-1:0]) | detected;
      end
   end

   // The held request drops only when the CPU takes the fixed vector.
   always @* begin
      nmi_edge = nonmaskable_edge_select ? (~nmi_prev & nmi_now)
                                         : (nmi_prev & ~nmi_now);
      next_nmi_pending = nmi_pending;
      if (accept_i && cpu_irq_o && cpu_vector_o == `NMI_VECTOR) begin
         next_nmi_pending = 1'b0;
      end
      // An edge in the cycle of acceptance is kept, so no request is lost.
      if (nmi_edge) begin
         next_nmi_pending = 1'b1;
      end
   end

   // I clear accepts both levels; in mode 1 with I set and the secondary
   // mask clear, only level-one sources pass.
   always @* begin
      pending      = request_status_reg & request_enable_reg;
      allow_level0 = ~int_mask_i;
      allow_level1 = ~int_mask_i
                     | (ctrl_mode_i == `MODE_ONE && !secondary_mask_bit_i);
      eligible     = pending & ((control_level_reg & {`LINES{allow_level1}})
                     | (~control_level_reg & {`LINES{allow_level0}}));
   end

   // Level one wins over level zero, then the lowest line number.
   always @* begin
      level1_hit = eligible & control_level_reg;
      if (|level1_hit) begin
         pick = lowest_set(level1_hit);
      end else begin
         pick = lowest_set(eligible);
      end
      // The spare top bit holds the carry; a base near the top would wrap.
      vector_sum = {1'b0, IRQ_VECTOR_BASE} + {6'h00, pick};
   end

   // Edge select of the non-maskable pin, one for rising.
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         nonmaskable_edge_select <= `RST_SYSTEM_CONTROL;
      end else if (reg_hit(addr_i, wr_i, `REG_SYSTEM_CONTROL)) begin
         nonmaskable_edge_select <= wdata_i[`NMI_EDGE_BIT];
      end
   end

   // Two sense bits per line.
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         request_sense_control <= `RST_SENSE;
      end else if (reg_hit(addr_i, wr_i, `REG_SENSE_CONTROL)) begin
         request_sense_control <= wdata_i;
      end
   end

   // A disabled line 2 to 7 still sets its flag (disabled lines 0 and 1 idle high), but no disabled line requests.
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         request_enable_reg <= `RST_LINE_BYTE;
      end else if (reg_hit(addr_i, wr_i, `REG_ENABLE)) begin
         request_enable_reg <= wdata_i[`LINES-1:0];
      end
   end

   // One control level bit per line.
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         control_level_reg <= `RST_LINE_BYTE;
      end else if (reg_hit(addr_i, wr_i, `REG_CONTROL_LEVEL)) begin
         control_level_reg <= wdata_i[`LINES-1:0];
      end
   end

   // Status flags: set by detections, cleared by software.
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         request_status_reg <= `RST_LINE_BYTE;
      end else begin
         request_status_reg <= next_status;
      end
   end

   // Pin history for edge detection, and the held non-maskable request.
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         line_prev   <= `RST_LINES_IDLE;
         nmi_prev    <= 1'b1;
         nmi_pending <= 1'b0;
      end else begin
         line_prev   <= line_now;
         nmi_prev    <= nmi_now;
         nmi_pending <= next_nmi_pending;
      end
   end

   // Outputs are registered, so the CPU sees a request one cycle after its cause.
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         cpu_irq_o <= 1'b0;
      end else begin
         cpu_irq_o <= next_nmi_pending | (|eligible);
      end
   end

   // The vector reads zero while nothing is requested.
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         cpu_vector_o <= `RST_VECTOR;
      end else if (next_nmi_pending) begin
         cpu_vector_o <= `NMI_VECTOR;
      end else if (|eligible) begin
         cpu_vector_o <= vector_sum[`VECTOR_W-1:0];
      end else begin
         cpu_vector_o <= `RST_VECTOR;
      end
   end

   // Wake ignores the CPU masks, but still needs the line enabled.
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         wake_o <= 1'b0;
      end else begin
         wake_o <= standby_i & (next_nmi_pending | (|(pending & `WAKE_LINES)));
      end
   end

   // Read data stand for as many cycles as the read strobe is held, one cycle late, then return to zero.
   always @* begin
      next_rdata = `RST_DATA;
      if (rd_i) begin
         case (addr_i)
            `REG_SYSTEM_CONTROL: next_rdata = {15'h0000, nonmaskable_edge_select};
            `REG_SENSE_CONTROL:  next_rdata = request_sense_control;
            `REG_ENABLE:         next_rdata = {8'h00, request_enable_reg};
            `REG_CONTROL_LEVEL:  next_rdata = {8'h00, control_level_reg};
            `REG_STATUS:         next_rdata = {8'h00, request_status_reg};
            `REG_ACCEPT_VIEW:    next_rdata = {7'h00, nmi_pending, cpu_vector_o};
            default:             next_rdata = `RST_DATA;
         endcase
      end
   end

   // Unmapped offsets read zero, so software can probe the map safely.
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         rdata_o <= `RST_DATA;
      end else begin
         rdata_o <= next_rdata;
      end
   end

endmodule // external_interrupt_sources

// ---- irq_src_assertions.sv ----
`timescale 1ns/1ps

module irq_src_assertions #(
   parameter [7:0] IRQ_VECTOR_BASE = 8'h10
) (
   // Clock and reset
   input wire        sys_clk_i,
   input wire        nrst_i,
   // Register port
   input wire [2:0]  addr_i,
   input wire        rd_i,
   input wire [15:0] rdata_o,
   // CPU side
   input wire        int_mask_i,
   input wire        secondary_mask_bit_i,
   input wire [1:0]  ctrl_mode_i,
   input wire        standby_i,
   input wire        cpu_irq_o,
   input wire [7:0]  cpu_vector_o,
   input wire        wake_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   property p_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("read data off slot");
   property p_high; $past(rd_i) && $past(addr_i) != 3'h1 && $past(addr_i) != 3'h5
      |-> rdata_o[15:8] == 8'h00; endproperty
   a_high: assert property (p_high) else $error("upper byte set");
   property p_view; $past(rd_i) && $past(addr_i) == 3'h5
      |-> rdata_o[7:0] == $past(cpu_vector_o); endproperty
   a_view: assert property (p_view) else $error("view vector wrong");
   property p_vec; cpu_irq_o
      |-> cpu_vector_o == 8'h07 || cpu_vector_o - IRQ_VECTOR_BASE < 8'h08; endproperty
   a_vec: assert property (p_vec) else $error("vector out of range");
   property p_m0; cpu_irq_o && $past(int_mask_i) && $past(ctrl_mode_i) != 2'h1
      |-> cpu_vector_o == 8'h07; endproperty
   a_m0: assert property (p_m0) else $error("masked line passed");
   property p_m1; cpu_irq_o && $past(int_mask_i) && $past(secondary_mask_bit_i)
      |-> cpu_vector_o == 8'h07; endproperty
   a_m1: assert property (p_m1) else $error("masked line passed");
   property p_wsb; wake_o |-> $past(standby_i); endproperty
   a_wsb: assert property (p_wsb) else $error("wake outside standby");
   property p_wnmi; $past(standby_i) && cpu_irq_o && cpu_vector_o == 8'h07 |-> wake_o;
   endproperty
   a_wnmi: assert property (p_wnmi) else $error("no wake on nmi");
endmodule  // irq_src_assertions

bind external_interrupt_sources irq_src_assertions #(.IRQ_VECTOR_BASE(IRQ_VECTOR_BASE)) u_chk (.*);

// ---- cpu_model.sv ----
`timescale 1ns/1ps

module cpu_model (
   // Clock and reset
   input  wire        sys_clk_i,
   input  wire        nrst_i,
   // Request and behaviour
   input  wire        irq_i,
   input  wire [7:0]  vector_i,
   input  wire        en_i,
   input  wire [3:0]  lag_i,
   // Acceptance
   output logic       accept_o,
   output logic [7:0] taken_o
);
   logic [3:0] wait_cnt;
   // The cycle after an acceptance only clears the count, so even a lag of zero takes the fixed vector once.
   always @(posedge sys_clk_i) begin
      accept_o <= 1'b0;
      if (!nrst_i) begin
         wait_cnt <= 4'h0;
         taken_o  <= 8'h00;
      end else if (!irq_i || !en_i || accept_o) begin
         wait_cnt <= 4'h0;
      end else if (wait_cnt == lag_i) begin
         accept_o <= 1'b1;
         taken_o  <= vector_i;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule  // cpu_model

// ---- external_interrupt_sources_bench.sv ----
`timescale 1ns/1ps

module external_interrupt_sources_bench;
   localparam [7:0] VB = 8'h10;
   logic        sys_clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        nmi_pin_i = 1'b1;
   logic [7:0]  irq_pin_i = 8'hFF;
   logic [15:0] key_sense_i = 16'hFFFF;
   logic [2:0]  addr_i = 3'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        int_mask_i = 1'b0;
   logic        secondary_mask_bit_i = 1'b0;
   logic [1:0]  ctrl_mode_i = 2'h0;
   logic        standby_i = 1'b0;
   logic        en = 1'b0;
   logic [3:0]  lag = 4'h1;
   logic        accept_i, cpu_irq_o, wake_o;
   logic [15:0] rdata_o;
   logic [7:0]  cpu_vector_o, taken;
   int          error_cnt = 0;
   int          comparisons = 0;

   always #10 sys_clk_i = ~sys_clk_i;

   external_interrupt_sources #(.IRQ_VECTOR_BASE(VB)) i_external_interrupt_sources (.*);
   cpu_model i_cpu_model (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .irq_i(cpu_irq_o),
      .vector_i(cpu_vector_o), .en_i(en), .lag_i(lag), .accept_o(accept_i), .taken_o(taken));

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      tick(1);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      @(posedge sys_clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      tick(1);
      rd_i <= 1'b0;
      chk(rdata_o, e);
   endtask

   task automatic mk(input logic [3:0] m, input logic [8:0] e);
      {ctrl_mode_i, int_mask_i, secondary_mask_bit_i} <= m;
      tick(3);
      chk({cpu_irq_o, cpu_irq_o ? cpu_vector_o : 8'h00}, e);
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic t_regs;
      wr(3'h5, 16'hFFFF);
      wr(3'h7, 16'hFFFF);
      for (int a = 0; a < 8; a++) rd(3'(a), 16'h0000);
      $display("regs done");
   endtask

   task automatic t_sense;
      for (int c = 0; c < 4; c++) begin
         wr(3'h1, 16'(c) << 4);
         wr(3'h4, 16'h0000);
         irq_pin_i[2] <= 1'b0;
         tick(5);
         rd(3'h4, {13'h0000, c != 2, 2'h0});
         wr(3'h4, 16'h0000);
         irq_pin_i[2] <= 1'b1;
         tick(5);
         rd(3'h4, {13'h0000, c != 1, 2'h0});
      end
      $display("sense done");
   endtask

   task automatic t_mask;
      wr(3'h1, 16'h0500);
      wr(3'h2, 16'h0030);
      wr(3'h3, 16'h0020);
      rd(3'h3, 16'h0020);
      irq_pin_i[5:4] <= 2'b00;
      tick(2);
      mk(4'h4, {1'b1, VB + 8'h05});
      mk(4'h6, {1'b1, VB + 8'h05});
      mk(4'h7, 9'h000);
      mk(4'h2, 9'h000);
      wr(3'h2, 16'h0010);
      mk(4'h0, {1'b1, VB + 8'h04});
      mk(4'h6, 9'h000);
      irq_pin_i <= 8'hFF;
      mk(4'h0, {1'b1, VB + 8'h04});
      wr(3'h2, 16'h0000);
      wr(3'h4, 16'h0000);
      $display("mask done");
   endtask

   task automatic t_keys;
      wr(3'h1, 16'h5000);
      rd(3'h1, 16'h5000);
      key_sense_i[9] <= 1'b0;
      tick(5);
      rd(3'h4, 16'h0080);
      key_sense_i[2] <= 1'b0;
      irq_pin_i[0]   <= 1'b0;
      tick(5);
      rd(3'h4, 16'h00C0);
      wr(3'h4, 16'h00BF);
      rd(3'h4, 16'h0080);
      wr(3'h2, 16'h0080);
      standby_i <= 1'b1;
      tick(2);
      chk(wake_o, 1'b1);
      irq_pin_i[3] <= 1'b0;
      wr(3'h2, 16'h0008);
      tick(5);
      chk(wake_o, 1'b0);
      wr(3'h2, 16'h0009);
      tick(6);
      chk(wake_o, 1'b1);
      rd(3'h2, 16'h0009);
      irq_pin_i   <= 8'hFF;
      key_sense_i <= 16'hFFFF;
      wr(3'h2, 16'h0000);
      tick(4);
      wr(3'h4, 16'h0000);
      $display("keys done");
   endtask

   task automatic t_nmi;
      {ctrl_mode_i, int_mask_i, secondary_mask_bit_i} <= 4'h7;
      en        <= 1'b1;
      nmi_pin_i <= 1'b0;
      tick(8);
      chk(taken, 8'h07);
      {ctrl_mode_i, int_mask_i, secondary_mask_bit_i} <= 4'h2;
      lag <= 4'h9;
      wr(3'h0, 16'h0001);
      nmi_pin_i <= 1'b1;
      tick(5);
      rd(3'h5, 16'h0107);
      tick(12);
      chk(cpu_irq_o, 1'b0);
      $display("nmi done");
   endtask

   initial begin
      tick(10);
      nrst_i <= 1'b1;
      t_regs();
      t_sense();
      t_mask();
      t_keys();
      standby_i <= 1'b1;
      t_nmi();
      test_done();
   end

   initial begin
      tick(5000);
      error_cnt++;
      test_done();
   end
endmodule  // external_interrupt_sources_bench
